// *** soe_pkg.sv ***
// Package with the constants and types of the status output encoder
package soe_pkg;

  // ************************************************************
  // Status patterns: {high, active, low, fault_free}
  // ************************************************************
  localparam logic [3:0] SOE_PAT_RESET = 4'h8;
  localparam logic [3:0] SOE_PAT_FATAL = 4'h8;
  localparam logic [3:0] SOE_PAT_CONTOUR = 4'ha;
  localparam logic [3:0] SOE_PAT_NO_REF = 4'h4;
  localparam logic [3:0] SOE_PAT_LIMIT = 4'hc;
  localparam logic [3:0] SOE_PAT_OTHER = 4'h6;
  localparam logic [3:0] SOE_PAT_STOP = 4'he;
  localparam logic [3:0] SOE_PAT_MAN_RUN = 4'h5;
  localparam logic [3:0] SOE_PAT_MAN_DONE = 4'hd;
  localparam logic [3:0] SOE_PAT_AUTO_RUN = 4'h7;
  localparam logic [3:0] SOE_PAT_AUTO_STOP = 4'hf;

  // ************************************************************
  // Error kinds
  // ************************************************************
  localparam logic [2:0] SOE_ERR_NONE = 3'h0;
  localparam logic [2:0] SOE_ERR_CONTOUR = 3'h1;
  localparam logic [2:0] SOE_ERR_NO_REF = 3'h2;
  localparam logic [2:0] SOE_ERR_LIMIT = 3'h3;
  localparam logic [2:0] SOE_ERR_OTHER = 3'h4;
  localparam logic [2:0] SOE_ERR_STOP = 3'h5;

  // ************************************************************
  // Display
  // ************************************************************
  localparam int SOE_DEPTH = 8;
  localparam int SOE_AW = 3;
  localparam logic [3:0] SOE_DIG_BLANK = 4'hf;
  localparam logic [3:0] SOE_DIG_MINUS = 4'he;
  // Flash half period 0.25 s at 250 MHz
  localparam int SOE_CLK_MHZ = 250;
  localparam int SOE_FLASH_MS = 250;
  localparam int SOE_FLASH_CYC = SOE_FLASH_MS * 1000 * SOE_CLK_MHZ;
  localparam logic [26:0] SOE_FLASH_RESET = 27'h0;

  // ************************************************************
  // Display modes
  // ************************************************************
  typedef enum logic [2:0] {
    SOE_DISP_OFF,
    SOE_DISP_READY,
    SOE_DISP_ERROR,
    SOE_DISP_VALUE,
    SOE_DISP_DIAG
  } soe_disp_t;

endpackage

// *** soe_code_mem.sv ***
// Small memory holding the queue of stored error codes
`timescale 1ns/10ps
module soe_code_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [soe_pkg::SOE_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [soe_pkg::SOE_AW-1:0] raddr,
  output logic [7:0] rdata
);
  import soe_pkg::*;

  logic [7:0] mem [SOE_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule // soe_code_mem

// *** soe_status_encoder.sv ***
// Status output encoder with error acknowledge and display control
`timescale 1ns/10ps
module soe_status_encoder (
  input wire logic clk,
  input wire logic rst_n,
  // Controller state
  input wire logic fatal_error,
  input wire logic power_ready,
  input wire logic err_contour,
  input wire logic err_no_ref,
  input wire logic err_limit,
  input wire logic err_other,
  input wire logic err_stop,
  input wire logic cause_present,
  input wire logic manual_running,
  input wire logic manual_done,
  input wire logic motor_turning,
  input wire logic dim_setting,
  input wire logic teach_ack,
  input wire logic new_action,
  input wire logic [7:0] err_code,
  input wire logic err_code_valid,
  // Pins and front panel
  input wire logic automatic_run_input,
  input wire logic fault_clear_input,
  input wire logic ack_key,
  input wire logic online_mode,
  input wire logic [7:0] output_ownership_param,
  input wire logic power_stage_init_cmd,
  input wire logic fieldbus_diag_function,
  input wire logic [3:0] fb_diag_in,
  input wire logic show_value,
  input wire logic signed [15:0] value_in,
  input wire logic [3:0] cmd_out,
  // Status outputs
  output logic func_flag_high,
  output logic active,
  output logic func_flag_low,
  output logic fault_free_flag,
  output logic err_pending,
  output logic err_ack_pulse,
  // Display: three digit codes, decimal points, diag lamps
  output logic [3:0] disp_dig2,
  output logic [3:0] disp_dig1,
  output logic [3:0] disp_dig0,
  output logic [2:0] disp_dp,
  output logic disp_ready,
  output logic disp_error,
  output logic [3:0] disp_diag,
  output soe_pkg::soe_disp_t disp_mode
);
  import soe_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic auto_prev_q;
  logic key_prev_q;
  logic auto_s, clr_s, key_s, init_s, diag_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= 5'h0;
      sync2_q <= 5'h0;
    end else begin
      sync1_q <= {fieldbus_diag_function, power_stage_init_cmd, ack_key,
                  fault_clear_input, automatic_run_input};
      sync2_q <= sync1_q;
    end
  end

  assign auto_s = sync2_q[0];
  assign clr_s = sync2_q[1];
  assign key_s = sync2_q[2];
  assign init_s = sync2_q[3];
  assign diag_s = sync2_q[4];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auto_prev_q <= 1'b0;
      key_prev_q <= 1'b0;
    end else begin
      auto_prev_q <= auto_s;
      key_prev_q <= key_s;
    end
  end

  logic auto_edge, key_press;
  assign auto_edge = auto_s ^ auto_prev_q;
  assign key_press = key_s & ~key_prev_q;

  // ************************************************************
  // Error state
  // ************************************************************
  logic fatal_q;
  logic [2:0] err_q;
  logic [2:0] err_new;
  logic ack_contour, ack_action, ack_any;

  always_comb begin
    err_new = SOE_ERR_NONE;
    if (err_stop) err_new = SOE_ERR_STOP;
    if (err_other) err_new = SOE_ERR_OTHER;
    if (err_limit) err_new = SOE_ERR_LIMIT;
    if (err_no_ref) err_new = SOE_ERR_NO_REF;
    if (err_contour) err_new = SOE_ERR_CONTOUR;
  end

  // Pin clear only for contouring, and never in on-line mode
  assign ack_contour = clr_s & ~online_mode
                       & (err_q == SOE_ERR_CONTOUR);
  assign ack_action = new_action & ~cause_present
                      & (err_q != SOE_ERR_CONTOUR)
                      & (err_q != SOE_ERR_NONE);
  assign ack_any = ack_contour | ack_action;

  // Fatal latches until mains cycle, which is the reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fatal_q <= 1'b0;
    end else if (fatal_error) begin
      fatal_q <= 1'b1;
    end
  end

  // A new error wins over an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_q <= SOE_ERR_NONE;
    end else if (err_new != SOE_ERR_NONE) begin
      err_q <= err_new;
    end else if (ack_any) begin
      err_q <= SOE_ERR_NONE;
    end
  end

  assign err_ack_pulse = ack_any;
  assign err_pending = err_q != SOE_ERR_NONE;

  // ************************************************************
  // Status output encoding
  // ************************************************************
  logic [3:0] status_d;
  logic [3:0] status_q;

  always_comb begin
    status_d = SOE_PAT_MAN_RUN;
    if (online_mode && output_ownership_param == 8'h0) begin
      status_d = cmd_out;
    end else if (fatal_q || !power_ready) begin
      status_d = SOE_PAT_FATAL;
    end else begin
      // Key acknowledge touches only the display, not err_q
      case (err_q)
        SOE_ERR_CONTOUR: status_d = SOE_PAT_CONTOUR;
        SOE_ERR_NO_REF: status_d = SOE_PAT_NO_REF;
        SOE_ERR_LIMIT: status_d = SOE_PAT_LIMIT;
        SOE_ERR_OTHER: status_d = SOE_PAT_OTHER;
        SOE_ERR_STOP: status_d = SOE_PAT_STOP;
        default: begin
          if ((auto_s && !motor_turning) || teach_ack) begin
            status_d = SOE_PAT_AUTO_STOP;
          end else if ((auto_s && motor_turning) || dim_setting) begin
            status_d = SOE_PAT_AUTO_RUN;
          end else if (manual_done && !manual_running) begin
            status_d = SOE_PAT_MAN_DONE;
          end else begin
            status_d = SOE_PAT_MAN_RUN;
          end
        end
      endcase
    end
  end

  // One register for all four pins keeps mixed patterns to skew
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= SOE_PAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign {func_flag_high, active, func_flag_low, fault_free_flag} =
    status_q;

  // ************************************************************
  // Stored error codes for the display
  // ************************************************************
  logic [SOE_AW-1:0] wr_q, rd_q;
  logic [SOE_AW:0] cnt_q;
  logic [7:0] code_rd;
  logic push, pop;

  assign push = err_code_valid && cnt_q != (SOE_AW+1)'(SOE_DEPTH);
  // Key, or level change on the run input, clears only the shown code
  assign pop = (key_press || auto_edge) && cnt_q != '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  soe_code_mem i_soe_code_mem (
    .clk(clk),
    .we(push),
    .waddr(wr_q),
    .wdata(err_code),
    .raddr(rd_q),
    .rdata(code_rd)
  );

  // ************************************************************
  // Flash timebase and power stage state
  // ************************************************************
  logic [26:0] flash_cnt_q;
  logic flash_q;
  logic pwr_on_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_cnt_q <= SOE_FLASH_RESET;
      flash_q <= 1'b0;
    end else if (flash_cnt_q == 27'(SOE_FLASH_CYC - 1)) begin
      flash_cnt_q <= SOE_FLASH_RESET;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 27'h1;
    end
  end

  // In on-line mode the stage counts as on only after the init command
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_on_q <= 1'b0;
    end else if (!power_ready) begin
      pwr_on_q <= 1'b0;
    end else if (!online_mode || init_s) begin
      pwr_on_q <= 1'b1;
    end
  end

  // ************************************************************
  // Display control
  // ************************************************************
  function automatic logic [3:0] soe_bcd(input logic [15:0] v,
                                         input int div);
    soe_bcd = 4'((v / 16'(div)) % 16'h000a);
  endfunction

  logic [15:0] mag;
  logic neg, big;
  assign neg = value_in < 0;
  assign mag = neg ? 16'(-value_in) : 16'(value_in);
  assign big = mag > 16'h0063;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disp_mode <= SOE_DISP_OFF;
      disp_dig2 <= SOE_DIG_BLANK;
      disp_dig1 <= SOE_DIG_BLANK;
      disp_dig0 <= SOE_DIG_BLANK;
      disp_dp <= 3'h0;
      disp_ready <= 1'b0;
      disp_error <= 1'b0;
      disp_diag <= 4'h0;
    end else begin
      disp_ready <= 1'b0;
      disp_error <= 1'b0;
      disp_dp <= 3'h0;
      disp_diag <= 4'h0;
      disp_dig2 <= SOE_DIG_BLANK;
      disp_dig1 <= SOE_DIG_BLANK;
      disp_dig0 <= SOE_DIG_BLANK;
      if (diag_s) begin
        disp_mode <= SOE_DISP_DIAG;
        disp_diag <= fb_diag_in;
      end else if (cnt_q != '0) begin
        disp_mode <= SOE_DISP_ERROR;
        disp_error <= 1'b1;
        // Code lit while flash_q is low; the timebase runs free, so a new error can wait up to a half period
        if (!flash_q) begin
          disp_dig1 <= code_rd[7:4];
          disp_dig0 <= code_rd[3:0];
        end
      end else if (show_value) begin
        disp_mode <= SOE_DISP_VALUE;
        disp_dig0 <= soe_bcd(mag, 1);
        disp_dig1 <= soe_bcd(mag, 10);
        if (neg && !big) begin
          disp_dig2 <= SOE_DIG_MINUS;
        end else begin
          disp_dig2 <= soe_bcd(mag, 100);
          if (neg) disp_dp <= flash_q ? 3'h0 : 3'h7;
        end
      end else if (pwr_on_q) begin
        disp_mode <= SOE_DISP_READY;
        disp_ready <= 1'b1;
      end else begin
        disp_mode <= SOE_DISP_OFF;
      end
    end
  end

endmodule // soe_status_encoder

// *** soe_status_encoder_props.sv ***
// Checker of the status output encoder port behaviour
`timescale 1ns/10ps
module soe_status_encoder_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fatal_error,
  input wire logic power_ready,
  input wire logic teach_ack,
  input wire logic err_contour,
  input wire logic fault_clear_input,
  input wire logic online_mode,
  input wire logic [7:0] output_ownership_param,
  input wire logic [3:0] cmd_out,
  input wire logic func_flag_high,
  input wire logic active,
  input wire logic func_flag_low,
  input wire logic fault_free_flag,
  input wire logic err_ack_pulse,
  input wire logic disp_ready
);
  import soe_pkg::*;
  wire [3:0] pat = {func_flag_high, active, func_flag_low, fault_free_flag};
  wire rel = online_mode && output_ownership_param == 8'h0;
  wire ok = power_ready && !fatal_error && !rel;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  fatal_pattern_a: assert property (
    fatal_error && !rel |-> ##[1:3] pat == SOE_PAT_FATAL)
    else $error("fatal pattern missing");
  power_pattern_a: assert property (
    !power_ready && !rel |-> ##[1:3] pat == SOE_PAT_FATAL)
    else $error("not ready pattern missing");
  output_release_a: assert property (
    (rel && $stable(cmd_out))[*4] |-> pat == cmd_out)
    else $error("outputs not released");
  contour_set_a: assert property (
    err_contour && ok && fault_free_flag |-> ##[1:3] pat == SOE_PAT_CONTOUR)
    else $error("contour pattern missing");
  contour_hold_a: assert property (
    (pat == SOE_PAT_CONTOUR && !fault_clear_input && ok)[*6]
    |=> pat == SOE_PAT_CONTOUR)
    else $error("contour cleared without clear input");
  ack_pulse_a: assert property (
    err_ack_pulse |=> !err_ack_pulse)
    else $error("acknowledge pulse too long");
  teach_pattern_a: assert property (
    teach_ack && fault_free_flag && ok |-> ##[1:3] pat == SOE_PAT_AUTO_STOP)
    else $error("teach pattern missing");
  ready_power_a: assert property (
    $rose(disp_ready) |-> $past(power_ready))
    else $error("ready shown without power");
endmodule // soe_status_encoder_props

bind soe_status_encoder soe_status_encoder_props i_soe_status_encoder_props (
  .clk(clk),
  .rst_n(rst_n),
  .fatal_error(fatal_error),
  .power_ready(power_ready),
  .teach_ack(teach_ack),
  .err_contour(err_contour),
  .fault_clear_input(fault_clear_input),
  .online_mode(online_mode),
  .output_ownership_param(output_ownership_param),
  .cmd_out(cmd_out),
  .func_flag_high(func_flag_high),
  .active(active),
  .func_flag_low(func_flag_low),
  .fault_free_flag(fault_free_flag),
  .err_ack_pulse(err_ack_pulse),
  .disp_ready(disp_ready)
);

// *** soe_master_model.sv ***
// Master controller model that takes a status pattern once stable
`timescale 1ns/10ps
module soe_master_model #(
  parameter int STABLE_CYC = 125000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] pins,
  output logic [3:0] seen_pat,
  output logic seen_valid
);
  logic [3:0] last_q;
  logic [31:0] cnt_q;
  // ************************************************************
  // Stability filter
  // ************************************************************
  // Pin skew makes mixed patterns, so only a still pattern counts
  always_ff @(posedge clk) begin
    if (!rst_n || pins != last_q) begin
      last_q <= pins;
      cnt_q <= 32'h0;
    end else if (cnt_q < STABLE_CYC) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  assign seen_valid = (cnt_q >= STABLE_CYC);
  assign seen_pat = last_q;
endmodule // soe_master_model

// *** tb_status_output_encoder.sv ***
// Testbench of the status output encoder
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_status_output_encoder;
  import soe_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, fatal_error = 1'b0, power_ready = 1'b0;
  logic err_contour = 1'b0, err_no_ref = 1'b0, err_limit = 1'b0;
  logic err_other = 1'b0, err_stop = 1'b0, cause_present = 1'b0;
  logic manual_running = 1'b0, manual_done = 1'b0, motor_turning = 1'b0;
  logic dim_setting = 1'b0, teach_ack = 1'b0, new_action = 1'b0;
  logic [7:0] err_code = 8'h0, output_ownership_param = 8'h0;
  logic err_code_valid = 1'b0, automatic_run_input = 1'b0, ack_key = 1'b0;
  logic fault_clear_input = 1'b0, online_mode = 1'b0, show_value = 1'b0;
  logic power_stage_init_cmd = 1'b0, fieldbus_diag_function = 1'b0;
  logic [3:0] fb_diag_in = 4'h0, cmd_out = 4'h0, seen_pat;
  logic signed [15:0] value_in = 16'sh0;
  logic func_flag_high, active, func_flag_low, fault_free_flag, seen_valid;
  logic err_pending, err_ack_pulse, disp_ready, disp_error;
  logic [3:0] disp_dig2, disp_dig1, disp_dig0, disp_diag;
  logic [2:0] disp_dp;
  soe_disp_t disp_mode;
  int errors = 0, num_checks = 0;
  wire [3:0] pins = {func_flag_high, active, func_flag_low, fault_free_flag};
  always #2 clk = ~clk;
  soe_status_encoder i_soe_status_encoder (
    .clk(clk), .rst_n(rst_n), .fatal_error(fatal_error),
    .power_ready(power_ready), .err_contour(err_contour),
    .err_no_ref(err_no_ref), .err_limit(err_limit), .err_other(err_other),
    .err_stop(err_stop), .cause_present(cause_present),
    .manual_running(manual_running), .manual_done(manual_done),
    .motor_turning(motor_turning), .dim_setting(dim_setting),
    .teach_ack(teach_ack), .new_action(new_action), .err_code(err_code),
    .err_code_valid(err_code_valid),
    .automatic_run_input(automatic_run_input),
    .fault_clear_input(fault_clear_input), .ack_key(ack_key),
    .online_mode(online_mode),
    .output_ownership_param(output_ownership_param),
    .power_stage_init_cmd(power_stage_init_cmd),
    .fieldbus_diag_function(fieldbus_diag_function),
    .fb_diag_in(fb_diag_in), .show_value(show_value), .value_in(value_in),
    .cmd_out(cmd_out), .func_flag_high(func_flag_high), .active(active),
    .func_flag_low(func_flag_low), .fault_free_flag(fault_free_flag),
    .err_pending(err_pending), .err_ack_pulse(err_ack_pulse),
    .disp_dig2(disp_dig2), .disp_dig1(disp_dig1), .disp_dig0(disp_dig0),
    .disp_dp(disp_dp), .disp_ready(disp_ready), .disp_error(disp_error),
    .disp_diag(disp_diag), .disp_mode(disp_mode));
  // Shortened stability time keeps the run brief
  soe_master_model #(.STABLE_CYC(8)) i_soe_master_model (.clk(clk),
    .rst_n(rst_n), .pins(pins), .seen_pat(seen_pat), .seen_valid(seen_valid));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic see(input logic [3:0] exp);
    int n;
    n = 0;
    tick(10);
    while (!(seen_valid && seen_pat === exp) && n < 60) begin
      tick(1);
      n++;
    end
    `CHK({seen_valid, seen_pat}, {1'b1, exp})
    if (!seen_valid) begin
      finish_test();
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
  endtask
  task automatic t_fatal();
    see(SOE_PAT_FATAL);
    power_ready <= 1'b1;
    manual_running <= 1'b1;
    see(SOE_PAT_MAN_RUN);
    manual_running <= 1'b0;
    manual_done <= 1'b1;
    see(SOE_PAT_MAN_DONE);
    fatal_error <= 1'b1;
    tick(2);
    fatal_error <= 1'b0;
    see(SOE_PAT_FATAL);
    tick(40);
    `CHK(pins, SOE_PAT_FATAL)
    manual_done <= 1'b0;
    manual_running <= 1'b1;
    do_reset();
    $display("test fatal done");
  endtask
  task automatic t_errors();
    logic [3:0] tab [5] = '{SOE_PAT_CONTOUR, SOE_PAT_NO_REF, SOE_PAT_LIMIT,
      SOE_PAT_OTHER, SOE_PAT_STOP};
    for (int i = 0; i < 5; i++) begin
      cause_present <= 1'b1;
      {err_contour, err_no_ref, err_limit, err_other, err_stop} <= 5'h10 >> i;
      tick(2);
      {err_contour, err_no_ref, err_limit, err_other, err_stop} <= 5'h0;
      see(tab[i]);
      `CHK(err_pending, 1'b1)
      ack_key <= 1'b1;
      new_action <= 1'b1;
      automatic_run_input <= 1'b1;
      tick(6);
      ack_key <= 1'b0;
      new_action <= 1'b0;
      automatic_run_input <= 1'b0;
      see(tab[i]);
      cause_present <= 1'b0;
      fault_clear_input <= (i == 0);
      new_action <= (i != 0);
      tick(1);
      `CHK(err_ack_pulse, i != 0)
      new_action <= 1'b0;
      tick(5);
      fault_clear_input <= 1'b0;
      see(SOE_PAT_MAN_RUN);
      `CHK(err_pending, 1'b0)
    end
    $display("test errors done");
  endtask
  task automatic t_online();
    online_mode <= 1'b1;
    cmd_out <= 4'h3;
    see(4'h3);
    output_ownership_param <= 8'h1;
    err_contour <= 1'b1;
    tick(2);
    err_contour <= 1'b0;
    fault_clear_input <= 1'b1;
    see(SOE_PAT_CONTOUR);
    online_mode <= 1'b0;
    tick(6);
    fault_clear_input <= 1'b0;
    see(SOE_PAT_MAN_RUN);
    $display("test online done");
  endtask
  task automatic t_auto();
    manual_running <= 1'b0;
    automatic_run_input <= 1'b1;
    motor_turning <= 1'b1;
    see(SOE_PAT_AUTO_RUN);
    motor_turning <= 1'b0;
    see(SOE_PAT_AUTO_STOP);
    automatic_run_input <= 1'b0;
    dim_setting <= 1'b1;
    see(SOE_PAT_AUTO_RUN);
    dim_setting <= 1'b0;
    teach_ack <= 1'b1;
    see(SOE_PAT_AUTO_STOP);
    teach_ack <= 1'b0;
    $display("test auto done");
  endtask
  task automatic t_disp();
    logic [8:0] exp_err [3] = '{9'h117, 9'h120, 9'h0ff};
    `CHK(disp_ready, 1'b1)
    show_value <= 1'b1;
    value_in <= -16'sd42;
    tick(6);
    `CHK({disp_dig2, disp_dig1, disp_dig0, disp_dp}, 15'h7210)
    value_in <= -16'sd251;
    tick(6);
    `CHK({disp_dig2, disp_dig1, disp_dig0, disp_dp}, 15'h128f)
    show_value <= 1'b0;
    err_code <= 8'h17;
    err_code_valid <= 1'b1;
    tick(1);
    err_code <= 8'h20;
    tick(1);
    err_code_valid <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      tick(6);
      `CHK({disp_error, disp_dig1, disp_dig0}, exp_err[k])
      // Second code is cleared by a run input level change, not the key
      if (k == 1) begin
        automatic_run_input <= 1'b1;
      end else begin
        ack_key <= 1'b1;
      end
      tick(6);
      ack_key <= 1'b0;
    end
    fieldbus_diag_function <= 1'b1;
    fb_diag_in <= 4'h5;
    tick(8);
    `CHK({disp_mode, disp_diag}, {SOE_DISP_DIAG, 4'h5})
    fieldbus_diag_function <= 1'b0;
    automatic_run_input <= 1'b0;
    online_mode <= 1'b1;
    do_reset();
    tick(6);
    `CHK(disp_ready, 1'b0)
    power_stage_init_cmd <= 1'b1;
    tick(8);
    `CHK(disp_ready, 1'b1)
    $display("test display done");
  endtask
  initial begin
    tick(8);
    rst_n <= 1'b1;
    t_fatal();
    t_errors();
    t_online();
    t_auto();
    t_disp();
    finish_test();
  end
endmodule // tb_status_output_encoder
